// ---- core/gatc_unit.sv ----
// bus address, terminator and interface command unit, instrument side
// What this block does
// - switch open: CR then LF terminators
// - fixed mode: EOI with the LF
// - switch closed: LF then CR, EOI on CR
// - variable mode terminators reloadable, lost at reset
// - talk/listen switches normally open, both roles
// - address from switches four to eight
// - factory address twelve
// - addresses zero to thirty accepted
// - low five bits match, top bits choose role
// - REN plus listen address gives remote
// - SRQ pulled low to request service
// - LLO locks out the front panel
// - DCL restores power-up defaults
// - addressed commands only when listen addressed
// - SDC clears like DCL when addressed
// - GTL returns to local when addressed
// - serial poll mode returns status byte
// - SPD ends serial poll, normal output
// - switches sampled only after reset release
// - UNL and UNT return to idle
// - command executes after full terminator pair
`timescale 1ns/1ps
`default_nettype none
module gatc_unit (
  input wire logic core_clk,
  input wire logic rst,
  // bus pins, low-true lines as inputs and open-drain drives
  input wire logic [7:0] dioIn_n,
  output logic [7:0] dioOut_n,
  output logic dioOe,
  input wire logic atnIn_n,
  input wire logic renIn_n,
  input wire logic ifcIn_n,
  input wire logic eoiIn_n,
  output logic eoiOut_n,
  output logic eoiOe,
  input wire logic davIn_n,
  output logic davOut_n,
  output logic davOe,
  input wire logic nrfdIn_n,
  output logic nrfdOut_n,
  output logic nrfdOe,
  input wire logic ndacIn_n,
  output logic ndacOut_n,
  output logic ndacOe,
  output logic srqOut_n,
  output logic srqOe,
  // rear panel switches, 1 = closed; [0]=sw1 ... [7]=sw8
  input wire logic [7:0] swIn,
  // instrument side
  input wire logic serviceReq,
  input wire logic [7:0] statusByte,
  input wire logic setTermValid,
  input wire logic [7:0] setTerm1,
  input wire logic [7:0] setTerm2,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic txLast,
  output logic txReady,
  output logic cmdValid,
  output logic [7:0] cmdData,
  output logic cmdEnd,
  input wire logic cmdReady,
  output logic remote,
  output logic lockout,
  output logic devClear,
  output logic talkAddr,
  output logic listenAddr,
  output logic serialPoll,
  output logic [4:0] busAddr
);
  // two-flop synchronisers for every pin
  logic [14:0] pinMeta_ff;
  logic [14:0] pinSync_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pinMeta_ff <= '0;
      pinSync_ff <= '0;
    end else begin
      pinMeta_ff <= {~ndacIn_n, ~nrfdIn_n, ~davIn_n, ~eoiIn_n, ~ifcIn_n, ~renIn_n,
                     ~atnIn_n, ~dioIn_n};
      pinSync_ff <= pinMeta_ff;
    end
  end
  logic [7:0] busByte;
  logic atn;
  logic ren;
  logic ifc;
  logic dav;
  logic nrfd;
  logic ndac;
  assign busByte = pinSync_ff[7:0];
  assign atn = pinSync_ff[8];
  assign ren = pinSync_ff[9];
  assign ifc = pinSync_ff[10];
  assign dav = pinSync_ff[12];
  assign nrfd = pinSync_ff[13];
  assign ndac = pinSync_ff[14];

  // switches pass their own synchroniser
  logic [7:0] swMeta_ff;
  logic [7:0] swSync_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      swMeta_ff <= '0;
      swSync_ff <= '0;
    end else begin
      swMeta_ff <= swIn;
      swSync_ff <= swMeta_ff;
    end
  end

  // switch capture once after release; later moves are ignored until next reset
  logic [1:0] swWait_ff;
  logic swTaken_ff;
  logic varTerm_ff;
  logic [4:0] myAddr_ff;
  logic talkDis_ff;
  logic listenDis_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      swWait_ff <= '0;
      swTaken_ff <= 1'b0;
      varTerm_ff <= 1'b0;
      myAddr_ff <= gatc_pkg::ADDR_DEFAULT;
      talkDis_ff <= 1'b0;
      listenDis_ff <= 1'b0;
    end else if (!swTaken_ff) begin
      swWait_ff <= swWait_ff + 2'h1;
      // tracks switch until capture
      varTerm_ff <= swSync_ff[0];
      if (swWait_ff == 2'h3) begin
        swTaken_ff <= 1'b1;
        // sw2 disables talk, sw3 disables listen
        talkDis_ff <= swSync_ff[1];
        listenDis_ff <= swSync_ff[2];
        // sw4 is weight 16, sw8 weight 1
        // sw5 and sw6 closed give twelve
        // thirty is the top usable code
        myAddr_ff <= swAddr(swSync_ff);
      end
    end
  end

  // address from the switch bank, 31 would be the untalk code so clamp
  function automatic logic [4:0] swAddr(input logic [7:0] sw);
    logic [4:0] a;
    a = {sw[3], sw[4], sw[5], sw[6], sw[7]};
    swAddr = (a > gatc_pkg::ADDR_MAX) ? gatc_pkg::ADDR_MAX : a;
  endfunction : swAddr

  // listener acceptor handshake
  gatc_pkg::gatc_acc_type accState_ff;
  logic [7:0] rxByte_ff;
  logic rxAtn_ff;
  logic rxEoi_ff;
  logic rxStrobe_ff;
  logic accEnable;
  logic cmdFull;
  assign accEnable = atn || (listenAddr && !cmdFull);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      accState_ff <= gatc_pkg::ACC_IDLE;
      rxByte_ff <= '0;
      rxAtn_ff <= 1'b0;
      rxEoi_ff <= 1'b0;
      rxStrobe_ff <= 1'b0;
    end else begin
      rxStrobe_ff <= 1'b0;
      unique case (accState_ff)
        gatc_pkg::ACC_IDLE: begin
          if (accEnable && !dav) begin
            accState_ff <= gatc_pkg::ACC_READY;
          end
        end
        gatc_pkg::ACC_READY: begin
          if (dav) begin
            rxByte_ff <= busByte;
            rxAtn_ff <= atn;
            rxEoi_ff <= pinSync_ff[11];
            rxStrobe_ff <= 1'b1;
            accState_ff <= gatc_pkg::ACC_TAKEN;
          end else if (!accEnable) begin
            accState_ff <= gatc_pkg::ACC_IDLE;
          end
        end
        gatc_pkg::ACC_TAKEN: accState_ff <= gatc_pkg::ACC_WAITOFF;
        gatc_pkg::ACC_WAITOFF: begin
          if (!dav) begin
            accState_ff <= gatc_pkg::ACC_IDLE;
          end
        end
      endcase
    end
  end
  // NRFD released only when ready; NDAC released once byte taken
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nrfdOe <= 1'b0;
      ndacOe <= 1'b0;
    end else begin
      nrfdOe <= (listenAddr || atn) && !(accEnable && accState_ff == gatc_pkg::ACC_READY);
      ndacOe <= (listenAddr || atn) && (accState_ff != gatc_pkg::ACC_TAKEN)
                && (accState_ff != gatc_pkg::ACC_WAITOFF);
    end
  end
  assign nrfdOut_n = 1'b0;
  assign ndacOut_n = 1'b0;

  // interface command decode; only bytes taken under ATN
  logic cmdByte;
  logic [6:0] code;
  logic clrPulse;
  assign cmdByte = rxStrobe_ff && rxAtn_ff;
  assign code = rxByte_ff[6:0];
  assign clrPulse = cmdByte && ((code == gatc_pkg::CMD_DCL) ||
                    (listenAddr && code == gatc_pkg::CMD_SDC));
  // addressing state, IFC clears both roles
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      talkAddr <= 1'b0;
      listenAddr <= 1'b0;
    end else if (ifc) begin
      talkAddr <= 1'b0;
      listenAddr <= 1'b0;
    end else if (cmdByte) begin
      if (code == gatc_pkg::CMD_UNL) begin
        listenAddr <= 1'b0;
      end else if (code == gatc_pkg::CMD_UNT) begin
        talkAddr <= 1'b0;
      // low five bits against the switch address
      end else if (code[6:5] == gatc_pkg::GRP_LISTEN && code[4:0] == myAddr_ff) begin
        listenAddr <= !listenDis_ff;
        talkAddr <= 1'b0;
      end else if (code[6:5] == gatc_pkg::GRP_TALK) begin
        talkAddr <= (code[4:0] == myAddr_ff) && !talkDis_ff;
        if (code[4:0] == myAddr_ff) begin
          listenAddr <= 1'b0;
        end
      end
    end
  end
  // remote, lockout and serial poll modes
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      remote <= 1'b0;
      lockout <= 1'b0;
      serialPoll <= 1'b0;
      devClear <= 1'b0;
    end else begin
      devClear <= clrPulse;
      if (!ren) begin
        remote <= 1'b0;
        lockout <= 1'b0;
      end else if (cmdByte) begin
        if (code[6:5] == gatc_pkg::GRP_LISTEN && code[4:0] == myAddr_ff) begin
          remote <= 1'b1;
        end
        if (code == gatc_pkg::CMD_LLO) begin
          lockout <= 1'b1;
        end
        // go to local only when addressed
        if (code == gatc_pkg::CMD_GTL && listenAddr) begin
          remote <= 1'b0;
        end
      end
      if (ifc) begin
        serialPoll <= 1'b0;
      end else if (cmdByte) begin
        // poll enable is taken as addressed; disable ends it
        if (code == gatc_pkg::CMD_SPE && listenAddr) begin
          serialPoll <= 1'b1;
        end else if (code == gatc_pkg::CMD_SPD) begin
          serialPoll <= 1'b0;
        end
      end
    end
  end

  // terminator pair, defaults reload on reset and on device clear
  logic [7:0] term1_ff;
  logic [7:0] term2_ff;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      term1_ff <= gatc_pkg::CHR_CR;
      term2_ff <= gatc_pkg::CHR_LF;
    end else if (!swTaken_ff || clrPulse) begin
      // CR then LF; LF then CR
      term1_ff <= varTerm_ff ? gatc_pkg::CHR_LF : gatc_pkg::CHR_CR;
      term2_ff <= varTerm_ff ? gatc_pkg::CHR_CR : gatc_pkg::CHR_LF;
    end else if (setTermValid && varTerm_ff) begin
      term1_ff <= setTerm1;
      term2_ff <= setTerm2;
    end
  end

  // received data line buffer, released after the terminator pair
  logic [gatc_pkg::CMD_AW-1:0] wrIdx_ff;
  logic [gatc_pkg::CMD_AW-1:0] rdIdx_ff;
  logic lineDone_ff;
  logic sawTerm1_ff;
  logic dataByte;
  logic [7:0] memRd;
  logic fifoInValid;
  logic fifoInReady;
  logic readPend_ff;
  assign dataByte = rxStrobe_ff && !rxAtn_ff && listenAddr;
  assign cmdFull = lineDone_ff || (wrIdx_ff == gatc_pkg::CMD_AW'(gatc_pkg::CMD_DEPTH-1));
  gatc_cmd_mem u_cmdMem (
    .core_clk(core_clk),
    .wrEn(dataByte && !cmdFull),
    .wrAddr(wrIdx_ff),
    .wrData(rxByte_ff),
    .rdAddr(rdIdx_ff),
    .rdData(memRd)
  );
  // hold the line until term1 then term2 arrive
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrIdx_ff <= '0;
      rdIdx_ff <= '0;
      lineDone_ff <= 1'b0;
      sawTerm1_ff <= 1'b0;
      readPend_ff <= 1'b0;
      cmdValid <= 1'b0;
      cmdData <= '0;
      cmdEnd <= 1'b0;
    end else if (clrPulse) begin
      wrIdx_ff <= '0;
      rdIdx_ff <= '0;
      lineDone_ff <= 1'b0;
      sawTerm1_ff <= 1'b0;
      readPend_ff <= 1'b0;
      cmdValid <= 1'b0;
      cmdEnd <= 1'b0;
    end else begin
      if (dataByte && !cmdFull) begin
        wrIdx_ff <= wrIdx_ff + 1'b1;
        sawTerm1_ff <= (rxByte_ff == term1_ff);
        if (sawTerm1_ff && rxByte_ff == term2_ff) begin
          lineDone_ff <= 1'b1;
        end
      end
      // drain one byte at a time; read data arrives a cycle later
      readPend_ff <= 1'b0;
      if (cmdValid && cmdReady) begin
        cmdValid <= 1'b0;
        if (cmdEnd) begin
          lineDone_ff <= 1'b0;
          wrIdx_ff <= '0;
          rdIdx_ff <= '0;
          sawTerm1_ff <= 1'b0;
        end
      end else if (lineDone_ff && !cmdValid && !readPend_ff) begin
        readPend_ff <= 1'b1;
        rdIdx_ff <= rdIdx_ff + 1'b1;
      end
      if (readPend_ff) begin
        cmdValid <= 1'b1;
        cmdData <= memRd;
        cmdEnd <= (rdIdx_ff == wrIdx_ff);
      end
    end
  end

  // talker output through a four-word buffer; bit 8 marks the last byte
  logic fifoOutValid;
  logic fifoOutReady;
  logic [8:0] fifoOut;
  gatc_fifo #(.WIDTH(gatc_pkg::DATA_W + 1), .DEPTH(gatc_pkg::FIFO_DEPTH)) u_txFifo (
    .core_clk(core_clk),
    .rst(rst),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData({txLast, txData}),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOut)
  );
  assign fifoInValid = txValid && txReady;
  // ready registered, so it trails a full buffer by a cycle; source must hold valid
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      txReady <= 1'b0;
    end else begin
      txReady <= fifoInReady && !(txReady && txValid);
    end
  end

  // source handshake with terminator insertion
  gatc_pkg::gatc_src_type srcState_ff;
  logic [1:0] termStep_ff;
  logic srcPoll_ff;
  logic talkActive;
  logic haveByte;
  assign talkActive = talkAddr && !atn;
  assign haveByte = serialPoll || fifoOutValid || (termStep_ff != 2'h0);
  assign fifoOutReady = (srcState_ff == gatc_pkg::SRC_RELEASE) && !srcPoll_ff
                        && (termStep_ff == 2'h0);
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      srcState_ff <= gatc_pkg::SRC_IDLE;
      termStep_ff <= 2'h0;
      srcPoll_ff <= 1'b0;
      dioOut_n <= 8'hff;
      dioOe <= 1'b0;
      davOe <= 1'b0;
      eoiOe <= 1'b0;
    end else if (!talkActive) begin
      srcState_ff <= gatc_pkg::SRC_IDLE;
      dioOe <= 1'b0;
      davOe <= 1'b0;
      eoiOe <= 1'b0;
    end else begin
      unique case (srcState_ff)
        gatc_pkg::SRC_IDLE: begin
          if (haveByte) begin
            srcPoll_ff <= serialPoll;
            dioOe <= 1'b1;
            eoiOe <= 1'b0;
            // status byte in place of data; bit 6 flags service
            if (serialPoll) begin
              dioOut_n <= ~{statusByte[7], serviceReq, statusByte[5:0]};
            end else if (termStep_ff == 2'h1) begin
              dioOut_n <= ~term1_ff;
            end else if (termStep_ff == 2'h2) begin
              dioOut_n <= ~term2_ff;
              eoiOe <= 1'b1;
            end else begin
              dioOut_n <= ~fifoOut[7:0];
            end
            srcState_ff <= gatc_pkg::SRC_WAITRDY;
          end
        end
        gatc_pkg::SRC_WAITRDY: begin
          if (!nrfd) begin
            davOe <= 1'b1;
            srcState_ff <= gatc_pkg::SRC_VALID;
          end
        end
        gatc_pkg::SRC_VALID: begin
          if (!ndac) begin
            davOe <= 1'b0;
            srcState_ff <= gatc_pkg::SRC_RELEASE;
          end
        end
        gatc_pkg::SRC_RELEASE: begin
          dioOe <= 1'b0;
          eoiOe <= 1'b0;
          if (!srcPoll_ff && termStep_ff == 2'h0) begin
            termStep_ff <= fifoOut[8] ? 2'h1 : 2'h0;
          end else if (!srcPoll_ff && termStep_ff == 2'h1) begin
            termStep_ff <= 2'h2;
          end else if (!srcPoll_ff) begin
            termStep_ff <= 2'h0;
          end
          srcState_ff <= gatc_pkg::SRC_IDLE;
        end
      endcase
    end
  end
  assign davOut_n = 1'b0;
  assign eoiOut_n = 1'b0;

  // service request, withdrawn during a poll answer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      srqOe <= 1'b0;
      busAddr <= gatc_pkg::ADDR_DEFAULT;
    end else begin
      srqOe <= serviceReq && !(serialPoll && talkAddr);
      busAddr <= myAddr_ff;
    end
  end
  assign srqOut_n = 1'b0;
endmodule : gatc_unit
`default_nettype wire

// ---- core/gatc_pkg.sv ----
// shared constants for the bus address, terminator and command unit
package gatc_pkg;
  // multiline command codes, with the parity bit cleared
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3f;
  localparam logic [6:0] CMD_UNT = 7'h5f;
  // address groups, selected by bits 6..5 of the byte
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK = 2'h2;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  localparam logic [4:0] ADDR_DEFAULT = 5'h0c;
  // terminator characters
  localparam logic [7:0] CHR_CR = 8'h0d;
  localparam logic [7:0] CHR_LF = 8'h0a;
  // data path sizes
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 4;
  localparam int CMD_DEPTH = 64;
  localparam int CMD_AW = 6;
  // listener acceptor states, gray along the usual path
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_READY = 2'b01,
    ACC_TAKEN = 2'b11,
    ACC_WAITOFF = 2'b10
  } gatc_acc_type;
  // talker source states
  typedef enum logic [1:0] {
    SRC_IDLE = 2'b00,
    SRC_WAITRDY = 2'b01,
    SRC_VALID = 2'b11,
    SRC_RELEASE = 2'b10
  } gatc_src_type;
endpackage : gatc_pkg

// ---- core/gatc_fifo.sv ----
// small first-in first-out buffer with valid and ready on each side
`timescale 1ns/1ps
`default_nettype none
module gatc_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wrPtr_ff;
  logic [AW-1:0] rdPtr_ff;
  logic [AW:0] count_ff;
  logic doWr;
  logic doRd;
  // honest flags from the fill count
  assign inReady = (count_ff != (AW+1)'(DEPTH));
  assign outValid = (count_ff != '0);
  assign outData = mem_ff[rdPtr_ff];
  assign doWr = inValid && inReady;
  assign doRd = outValid && outReady;
  // storage, no reset needed on the data words
  always_ff @(posedge core_clk) begin
    if (doWr) begin
      mem_ff[wrPtr_ff] <= inData;
    end
  end
  // pointers and fill count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (doWr) begin
        wrPtr_ff <= (wrPtr_ff == AW'(DEPTH-1)) ? '0 : wrPtr_ff + 1'b1;
      end
      if (doRd) begin
        rdPtr_ff <= (rdPtr_ff == AW'(DEPTH-1)) ? '0 : rdPtr_ff + 1'b1;
      end
      if (doWr && !doRd) begin
        count_ff <= count_ff + 1'b1;
      end else if (doRd && !doWr) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end
endmodule : gatc_fifo
`default_nettype wire

// ---- core/gatc_cmd_mem.sv ----
// command line memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module gatc_cmd_mem (
  input wire logic core_clk,
  input wire logic wrEn,
  input wire logic [gatc_pkg::CMD_AW-1:0] wrAddr,
  input wire logic [gatc_pkg::DATA_W-1:0] wrData,
  input wire logic [gatc_pkg::CMD_AW-1:0] rdAddr,
  output logic [gatc_pkg::DATA_W-1:0] rdData
);
  logic [gatc_pkg::DATA_W-1:0] mem_ff [gatc_pkg::CMD_DEPTH];
  // write port
  always_ff @(posedge core_clk) begin
    if (wrEn) begin
      mem_ff[wrAddr] <= wrData;
    end
  end
  // read data from a register
  always_ff @(posedge core_clk) begin
    rdData <= mem_ff[rdAddr];
  end
endmodule : gatc_cmd_mem
`default_nettype wire

// ---- dv/gatc_unit_checker.sv ----
// port checker for the command unit
`timescale 1ns/1ps
`default_nettype none
module gatc_unit_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] dioOut_n,
  input wire logic dioOe,
  input wire logic eoiOe,
  input wire logic davOe,
  input wire logic nrfdOe,
  input wire logic ndacOe,
  input wire logic davIn_n,
  input wire logic renIn_n,
  input wire logic srqOe,
  input wire logic [7:0] swIn,
  input wire logic serviceReq,
  input wire logic [7:0] statusByte,
  input wire logic remote,
  input wire logic devClear,
  input wire logic talkAddr,
  input wire logic serialPoll,
  input wire logic [4:0] busAddr
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  // acceptor steps: byte taken, then held until dav goes high
  sequence s_take;
    $fell(ndacOe) && !davIn_n;
  endsequence
  sequence s_held;
    !ndacOe && !davIn_n;
  endsequence
  a_take_holds_nrfd: assert property (s_take |-> nrfdOe)
    else $error("nrfd free at accept");
  a_accept_stays: assert property (s_held |=> !ndacOe)
    else $error("ndac pulled while dav low");
  a_dav_with_data: assert property (davOe |-> dioOe)
    else $error("dav without data");
  a_eoi_on_lf: assert property ((eoiOe && davOe && !swIn[0])
    |-> dioOut_n == ~gatc_pkg::CHR_LF)
    else $error("eoi not with line feed");
  a_poll_byte: assert property ((serialPoll && talkAddr && davOe)
    |-> dioOut_n == ~{statusByte[7], serviceReq, statusByte[5:0]})
    else $error("wrong poll byte");
  a_srq_follows: assert property ($rose(serviceReq) |-> ##[1:6] srqOe)
    else $error("srq not pulled");
  a_addr_range: assert property (busAddr <= gatc_pkg::ADDR_MAX)
    else $error("address above range");
  a_clear_pulse: assert property (devClear |=> !devClear)
    else $error("clear longer than a cycle");
  a_talk_drive: assert property (dioOe |-> talkAddr)
    else $error("data driven while not talker");
  a_remote_ren: assert property ($rose(remote) |-> !renIn_n)
    else $error("remote without ren");
endmodule : gatc_unit_checker
bind gatc_unit gatc_unit_checker i_gatc_unit_checker (
  .core_clk, .rst, .dioOut_n, .dioOe, .eoiOe, .davOe, .nrfdOe, .ndacOe, .davIn_n,
  .renIn_n, .srqOe, .swIn, .serviceReq, .statusByte, .remote, .devClear, .talkAddr,
  .serialPoll, .busAddr
);
`default_nettype wire

// ---- dv/gatc_ctl_model.sv ----
// bus controller model: sends bytes and reads talker bytes
`timescale 1ns/1ps
`default_nettype none
module gatc_ctl_model (
  input wire logic core_clk,
  input wire logic [7:0] dio_n,
  input wire logic dav_n,
  input wire logic nrfd_n,
  input wire logic ndac_n,
  input wire logic eoi_n,
  output logic [7:0] cDio,
  output logic cDioOe,
  output logic cAtnOe,
  output logic cDavOe,
  output logic cNrfdOe,
  output logic cNdacOe
);
  // idle: not ready and not accepted, so no talker runs ahead
  initial begin
    {cDio, cDioOe, cAtnOe, cDavOe} = '0;
    {cNrfdOe, cNdacOe} = 2'b11;
  end
  // atn settles before acceptor lines are freed
  task automatic send(input logic [7:0] d, input logic atn);
    @(negedge core_clk);
    cAtnOe = atn;
    repeat (4) @(negedge core_clk);
    {cNrfdOe, cNdacOe} = 2'b00;
    cDio = d;
    cDioOe = 1'b1;
    @(negedge core_clk);
    while (!nrfd_n) @(negedge core_clk);
    cDavOe = 1'b1;
    while (!ndac_n) @(negedge core_clk);
    {cDavOe, cDioOe} = 2'b00;
    repeat (12) @(negedge core_clk);
  endtask : send
  // acceptor side, one byte and its end flag
  task automatic recv(output logic [7:0] d, output logic e);
    @(negedge core_clk);
    {cNrfdOe, cNdacOe} = 2'b11;
    cAtnOe = 1'b0;
    repeat (2) @(negedge core_clk);
    cNrfdOe = 1'b0;
    while (dav_n) @(negedge core_clk);
    d = ~dio_n;
    e = !eoi_n;
    {cNrfdOe, cNdacOe} = 2'b10;
    while (!dav_n) @(negedge core_clk);
    cNdacOe = 1'b1;
  endtask : recv
endmodule : gatc_ctl_model
`default_nettype wire

// ---- dv/gatc_unit_bench.sv ----
// self-checking bench for the command unit
`timescale 1ns/1ps
`default_nettype none
module gatc_unit_bench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic renOe = 1'b0;
  logic serviceReq = 1'b0;
  logic setTermValid = 1'b0;
  logic txValid = 1'b0;
  logic [7:0] swIn = 8'h30;
  logic [7:0] txData = 8'h00;
  logic [7:0] setTerm1 = 8'h00;
  logic [7:0] setTerm2 = 8'h00;
  logic [7:0] statusByte = 8'h85;
  logic [7:0] dioOut_n, cmdData, cDio;
  logic [4:0] busAddr;
  logic dioOe, eoiOe, davOe, nrfdOe, ndacOe, srqOe, txReady, cmdValid, cmdEnd;
  logic remote, lockout, devClear, talkAddr, listenAddr, serialPoll;
  logic cDioOe, cAtnOe, cDavOe, cNrfdOe, cNdacOe;
  int fails = 0;
  int testsRun = 0;
  int cyc = 0;
  int clrCnt = 0;
  int endCnt = 0;
  logic [7:0] q[$];
  // open-drain lines: low while any party pulls, pull-up otherwise
  wire logic [7:0] dio_n = (dioOe ? dioOut_n : 8'hff) & (cDioOe ? ~cDio : 8'hff);
  wire logic dav_n = !(davOe || cDavOe);
  wire logic nrfd_n = !(nrfdOe || cNrfdOe);
  wire logic ndac_n = !(ndacOe || cNdacOe);
  wire logic eoi_n = !eoiOe;
  gatc_unit i_gatc_unit (
    .core_clk, .rst, .dioIn_n(dio_n), .dioOut_n, .dioOe, .atnIn_n(!cAtnOe),
    .renIn_n(!renOe), .ifcIn_n(1'b1), .eoiIn_n(eoi_n), .eoiOut_n(), .eoiOe,
    .davIn_n(dav_n), .davOut_n(), .davOe, .nrfdIn_n(nrfd_n), .nrfdOut_n(), .nrfdOe,
    .ndacIn_n(ndac_n), .ndacOut_n(), .ndacOe, .srqOut_n(), .srqOe, .swIn, .serviceReq,
    .statusByte, .setTermValid, .setTerm1, .setTerm2, .txValid, .txData,
    .txLast(1'b1), .txReady, .cmdValid, .cmdData, .cmdEnd, .cmdReady(1'b1), .remote,
    .lockout, .devClear, .talkAddr, .listenAddr, .serialPoll, .busAddr
  );
  gatc_ctl_model i_gatc_ctl_model (
    .core_clk, .dio_n, .dav_n, .nrfd_n, .ndac_n, .eoi_n, .cDio, .cDioOe, .cAtnOe,
    .cDavOe, .cNrfdOe, .cNdacOe
  );
  // free-running clock
  initial forever #5 core_clk = ~core_clk;
  // collect line bytes and clear pulses; watchdog well above the run
  always @(posedge core_clk) begin
    cyc++;
    if (cmdValid === 1'b1) q.push_back(cmdData);
    if (cmdValid === 1'b1 && cmdEnd === 1'b1) endCnt++;
    if (devClear === 1'b1) clrCnt++;
    if (cyc == 20000) begin
      fails++;
      end_sim;
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    testsRun++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", testsRun, fails);
    if (fails == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  task automatic snd(input logic [7:0] d, input logic atn);
    i_gatc_ctl_model.send(d, atn);
  endtask : snd
  // switches must be steady across the release
  task automatic do_reset;
    rst = 1'b1;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    repeat (10) @(negedge core_clk);
  endtask : do_reset
  // listen, remote, then a line released only after both terminators
  task automatic t_listen;
    renOe = 1'b1;
    snd({1'b0, gatc_pkg::GRP_LISTEN, 5'd12}, 1'b1);
    chk({6'h00, listenAddr, remote}, 8'h03);
    snd(8'h41, 1'b0);
    snd(gatc_pkg::CHR_CR, 1'b0);
    chk(8'(q.size()), 8'h00);
    snd(gatc_pkg::CHR_LF, 1'b0);
    for (int i = 0; i < 50 && endCnt == 0; i++) @(negedge core_clk);
    chk(q[0], 8'h41);
    chk(q[1], gatc_pkg::CHR_CR);
    chk(q[2], gatc_pkg::CHR_LF);
    chk(8'(endCnt), 8'h01);
  endtask : t_listen
  // universal and addressed commands, SDC ignored when unlistened
  task automatic t_cmds;
    snd({1'b0, gatc_pkg::CMD_LLO}, 1'b1);
    chk({7'h00, lockout}, 8'h01);
    snd({1'b0, gatc_pkg::CMD_GTL}, 1'b1);
    chk({7'h00, remote}, 8'h00);
    snd({1'b0, gatc_pkg::CMD_UNL}, 1'b1);
    chk({7'h00, listenAddr}, 8'h00);
    snd({1'b0, gatc_pkg::CMD_SDC}, 1'b1);
    chk(8'(clrCnt), 8'h00);
    snd({1'b0, gatc_pkg::GRP_LISTEN, 5'd12}, 1'b1);
    snd({1'b0, gatc_pkg::CMD_SDC}, 1'b1);
    chk(8'(clrCnt), 8'h01);
    snd({1'b0, gatc_pkg::CMD_DCL}, 1'b1);
    chk(8'(clrCnt), 8'h02);
  endtask : t_cmds
  // one byte out, the two terminators follow, end flag on the last only
  task automatic t_talk(input logic [4:0] a, input logic [7:0] t1, input logic [7:0] t2);
    logic [7:0] d[3];
    logic e[3];
    @(negedge core_clk);
    txData = 8'h5a;
    txValid = 1'b1;
    while (txReady !== 1'b1) @(negedge core_clk);
    @(negedge core_clk);
    txValid = 1'b0;
    snd({1'b0, gatc_pkg::GRP_TALK, a}, 1'b1);
    for (int i = 0; i < 3; i++) i_gatc_ctl_model.recv(d[i], e[i]);
    chk(d[0], 8'h5a);
    chk(d[1], t1);
    chk(d[2], t2);
    chk({5'h00, e[0], e[1], e[2]}, 8'h01);
    snd({1'b0, gatc_pkg::CMD_UNT}, 1'b1);
    chk({7'h00, talkAddr}, 8'h00);
  endtask : t_talk
  // service request, then poll byte instead of data until disabled
  task automatic t_poll;
    logic [7:0] d;
    logic e;
    serviceReq = 1'b1;
    repeat (8) @(negedge core_clk);
    chk({7'h00, srqOe}, 8'h01);
    snd({1'b0, gatc_pkg::GRP_LISTEN, 5'd12}, 1'b1);
    snd({1'b0, gatc_pkg::CMD_SPE}, 1'b1);
    snd({1'b0, gatc_pkg::GRP_TALK, 5'd12}, 1'b1);
    i_gatc_ctl_model.recv(d, e);
    chk(d, {statusByte[7], 1'b1, statusByte[5:0]});
    snd({1'b0, gatc_pkg::CMD_SPD}, 1'b1);
    chk({7'h00, serialPoll}, 8'h00);
    snd({1'b0, gatc_pkg::CMD_UNT}, 1'b1);
    serviceReq = 1'b0;
  endtask : t_poll
  // switches read once; a new reset picks address 30 and variable mode
  task automatic t_var;
    swIn = 8'hf9;
    repeat (10) @(negedge core_clk);
    chk({3'h0, busAddr}, 8'h0c);
    do_reset;
    chk({3'h0, busAddr}, {3'h0, gatc_pkg::ADDR_MAX});
    t_talk(5'd30, gatc_pkg::CHR_LF, gatc_pkg::CHR_CR);
    setTerm1 = 8'h21;
    setTerm2 = 8'h22;
    setTermValid = 1'b1;
    @(negedge core_clk);
    setTermValid = 1'b0;
    t_talk(5'd30, 8'h21, 8'h22);
  endtask : t_var
  // main sequence
  initial begin
    do_reset;
    chk({3'h0, busAddr}, 8'h0c);
    t_listen;
    t_cmds;
    t_talk(5'd12, gatc_pkg::CHR_CR, gatc_pkg::CHR_LF);
    t_poll;
    t_var;
    end_sim;
  end
endmodule : gatc_unit_bench
`default_nettype wire
